/* File: common/rx_report_regs.svh */
// Purpose: offsets, field positions, reset values and counts of the
//          error and frequency reporting block
// Assumes: 8-bit register port, byte addresses
// Notes:   definitions only
`ifndef RX_REPORT_REGS_SVH
`define RX_REPORT_REGS_SVH

// register offsets
`define ADDR_STATUS 8'h00
`define ADDR_MASK 8'h04
`define ADDR_INFO 8'h08
`define ADDR_CS_SUB1 8'h0c
`define ADDR_CS_SUB2 8'h10

// status and mask bit positions
`define ST_ERR_RISE 0
`define ST_FREQ_UPD 1
`define ST_UNLOCK 2
`define ST_BLOCK 3
`define ST_WIDTH 4

// reset values
`define MASK_RST 4'h0
`define STATUS_RST 4'h0

// frame and clock counts
`define CLR_MCK_CYCLES 4'h8
`define CBL_HIGH_FRAMES 8'h20
`define BLOCK_FRAMES 8'hc0
`define THIRD_FRAMES 8'h40
`define CS_SHOWN_BITS 8'h06
`define GOOD_WINDOWS 2'h2
`define MCK_PER_FRAME_SHIFT 9
`define REF_NOM_KHZ 6144

// reference edges counted over one third of a block
`define FREQ_MIN 16'h0dac
`define FREQ_96_88 16'h10b5
`define FREQ_88_48 16'h18b5
`define FREQ_48_44 16'h216a
`define FREQ_44_32 16'h296a
`define FREQ_MAX 16'h36b0

`endif

/* File: common/rx_report_pkg.sv */
// Purpose: types shared by the reporting block
// Assumes: nothing
// Notes:   codes are the block's own encodings
package rx_report_pkg;

    // frequency code on the freq_code_bits pins
    typedef enum logic [2:0] {
        FREQ_NONE = 3'b000,
        FREQ_96K = 3'b001,
        FREQ_88K2 = 3'b010,
        FREQ_48K = 3'b011,
        FREQ_44K1 = 3'b100,
        FREQ_32K = 3'b101
    } freq_code_t;

    // error code, higher value is higher priority
    typedef enum logic [2:0] {
        ERR_NONE = 3'b000,
        ERR_COND0 = 3'b001,
        ERR_COND1 = 3'b010,
        ERR_COND2 = 3'b011,
        ERR_COND3 = 3'b100,
        ERR_PARITY = 3'b101,
        ERR_BIPHASE = 3'b110,
        ERR_UNLOCK = 3'b111
    } err_code_t;

endpackage

/* File: hw/rx_err_latch.sv */
// Purpose: prioritised, latched error code
// Assumes: conditions are levels on the block clock
// Notes:   a condition present during the clear is kept
`include "rx_report_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_err_latch (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_clr,
    input wire logic [6:0] i_cond,
    // code
    output rx_report_pkg::err_code_t o_code
);

    rx_report_pkg::err_code_t code_ff;
    logic [2:0] cur;

    // highest set condition wins
    always_comb begin
        cur = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (i_cond[i]) begin
                cur = 3'(i + 1);
            end
        end
    end

    // latch keeps the worst since the last clear; set beats clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            code_ff <= rx_report_pkg::ERR_NONE;
        end else if (i_clr) begin
            code_ff <= rx_report_pkg::err_code_t'(cur); // RL5
        end else if (cur > code_ff) begin
            code_ff <= rx_report_pkg::err_code_t'(cur); // RL4
        end
    end

    assign o_code = code_ff;

    property p_never_drops;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_clr |=> code_ff >= $past(code_ff);
    endproperty
    a_never_drops: assert property (p_never_drops) // RL4
        else $error("error code dropped without clear");

    property p_takes_worst;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_cond[6] |=> code_ff == rx_report_pkg::ERR_UNLOCK;
    endproperty
    a_takes_worst: assert property (p_takes_worst) // RL4
        else $error("unlock not shown as top error");

endmodule
`default_nettype wire

/* File: hw/rx_freq_meter.sv */
// Purpose: sample frequency code from reference clock edge counts
// Assumes: reference level already synchronised
// Notes:   one window is a third of a block
`include "rx_report_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_freq_meter (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // timing and status
    input wire logic i_ref_level,
    input wire logic i_third_tick,
    input wire logic i_locked,
    // code
    output rx_report_pkg::freq_code_t o_code,
    output logic o_upd
);

    logic ref_d_ff;
    logic [15:0] cnt_ff;
    logic [1:0] good_ff;
    rx_report_pkg::freq_code_t code_ff;
    logic upd_ff;
    rx_report_pkg::freq_code_t meas;
    logic full_ff;

    // map edge count to code
    always_comb begin
        meas = rx_report_pkg::FREQ_NONE;
        if (cnt_ff < `FREQ_MIN || cnt_ff > `FREQ_MAX) meas = rx_report_pkg::FREQ_NONE;
        else if (cnt_ff < `FREQ_96_88) meas = rx_report_pkg::FREQ_96K;
        else if (cnt_ff < `FREQ_88_48) meas = rx_report_pkg::FREQ_88K2;
        else if (cnt_ff < `FREQ_48_44) meas = rx_report_pkg::FREQ_48K;
        else if (cnt_ff < `FREQ_44_32) meas = rx_report_pkg::FREQ_44K1;
        else meas = rx_report_pkg::FREQ_32K;
    end

    // count rising reference edges, saturating
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_third_tick) begin
            cnt_ff <= 16'h0000;
            ref_d_ff <= i_rst_n ? i_ref_level : 1'b0;
        end else begin
            ref_d_ff <= i_ref_level;
            if (i_ref_level && !ref_d_ff && cnt_ff != 16'hffff) cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    // update three times a block; needs two good windows in a row
    always_ff @(posedge i_clk) begin
        upd_ff <= 1'b0;
        if (!i_rst_n || !i_locked) begin
            good_ff <= 2'h0; // RL8
            code_ff <= rx_report_pkg::FREQ_NONE; // RL8
            full_ff <= 1'b0;
        end else if (i_third_tick) begin
            upd_ff <= 1'b1; // RL7
            full_ff <= 1'b1;
            // a window cut short by reset or unlock counts too few edges to trust
            if (!full_ff || meas == rx_report_pkg::FREQ_NONE) begin // RL6
                good_ff <= 2'h0;
                code_ff <= rx_report_pkg::FREQ_NONE;
            end else begin
                good_ff <= (good_ff == `GOOD_WINDOWS) ? good_ff : good_ff + 2'h1;
                code_ff <= (good_ff != 2'h0) ? meas : rx_report_pkg::FREQ_NONE; // RL6
            end
        end
    end

    assign o_code = code_ff;
    assign o_upd = upd_ff;

    property p_unlock_invalid;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_locked |=> code_ff == rx_report_pkg::FREQ_NONE;
    endproperty
    a_unlock_invalid: assert property (p_unlock_invalid) // RL8
        else $error("frequency code valid while unlocked");

    property p_two_windows;
        @(posedge i_clk) disable iff (!i_rst_n)
        code_ff != rx_report_pkg::FREQ_NONE |-> good_ff == `GOOD_WINDOWS;
    endproperty
    a_two_windows: assert property (p_two_windows) // RL6
        else $error("frequency code valid too early");

endmodule
`default_nettype wire

/* File: hw/rx_report_top.sv */
// Purpose: error and frequency reporting of a biphase audio receiver
// Assumes: receiver core events arrive on I_SYS_CLK; pins are async
// Notes:   status pins are shared between channel status and reports
//
// Notes on behaviour
// RL1: select high routes chosen subframe status
// RL2: select low makes pin the frequency reference
// RL3: error code shown only while select low
// RL4: error code is prioritised and latched
// RL5: select high over eight master clocks clears
// RL6: frequency valid after two thirds block reference
// RL7: frequency updates three times a block
// RL8: frequency invalid while recovery loop unlocked
// RL9: sample flag on parity, biphase or unlock
// RL10: master clock at 256 times sample rate
// RL11: all four format pins high resets
// RL12: select chooses status or reports on pins
// RL13: block start high first four bytes
// RL14: status pins update at block start rise
// RL15: own error priority and frequency code tables
//
// The address map and the address-and-strobe port were left to the implementer.
`include "rx_report_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_report_top (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // pins from the controller
    input wire logic I_REPORT_SEL,
    input wire logic I_SUBSEL_FREQCLK,
    input wire logic [3:0] I_FORMAT_SELECT_PINS,
    // receiver core events
    input wire logic I_FRAME_TICK,
    input wire logic I_BLOCK_TICK,
    input wire logic I_SUBFRAME_DONE,
    input wire logic I_SUBFRAME_ID,
    input wire logic I_CS_BIT,
    input wire logic I_PARITY_ERR,
    input wire logic I_BIPHASE_ERR,
    input wire logic I_LOCKED,
    input wire logic [3:0] I_ERR_COND,
    // register port
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // pins to the controller
    output logic [5:0] O_STATUS_PINS,
    output logic O_BLOCK_START,
    output logic O_SAMPLE_ERR,
    output logic O_MCK,
    output logic O_IRQ
);

    // pin synchronisers: [0] select, [1] shared pin, [5:2] format
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic sel_s;
    logic sub_s;
    logic fmt_reset;
    logic rst_n_int;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
        end else begin
            sync1_ff <= {I_FORMAT_SELECT_PINS, I_SUBSEL_FREQCLK, I_REPORT_SEL};
            sync2_ff <= sync1_ff;
        end
    end

    assign sel_s = sync2_ff[0];
    assign sub_s = sync2_ff[1];
    // the controller resets us by raising every format pin
    assign fmt_reset = &sync2_ff[5:2]; // RL11
    assign rst_n_int = I_RST_N && !fmt_reset; // RL11

    // frame position inside the block
    logic [7:0] frame_idx_ff;
    logic third_tick;

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            frame_idx_ff <= 8'h00;
        end else if (I_FRAME_TICK) begin
            if (I_BLOCK_TICK || frame_idx_ff == `BLOCK_FRAMES - 8'h01) begin
                frame_idx_ff <= 8'h00;
            end else begin
                frame_idx_ff <= frame_idx_ff + 8'h01;
            end
        end
    end

    // windows start at frames 0, 64 and 128; first one at the boundary
    assign third_tick = I_FRAME_TICK && (I_BLOCK_TICK
        || frame_idx_ff + 8'h01 == `THIRD_FRAMES
        || frame_idx_ff + 8'h01 == `THIRD_FRAMES + `THIRD_FRAMES); // RL7

    // block start indicator: 32 frames high, 160 low
    logic blk_ff;

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            blk_ff <= 1'b0;
        end else if (I_FRAME_TICK) begin
            blk_ff <= I_BLOCK_TICK || (frame_idx_ff + 8'h01 < `CBL_HIGH_FRAMES); // RL13
        end
    end

    assign O_BLOCK_START = blk_ff;

    // channel status capture per subframe, shown from the next block
    logic [5:0] cs_cap_ff [2];
    logic [5:0] cs_shown_ff [2];

    generate
        for (genvar g = 0; g < 2; g++) begin : g_sub
            always_ff @(posedge I_SYS_CLK) begin
                if (!rst_n_int) begin
                    cs_cap_ff[g] <= 6'h00;
                    cs_shown_ff[g] <= 6'h00;
                end else begin
                    if (I_SUBFRAME_DONE && I_SUBFRAME_ID == 1'(g)
                        && frame_idx_ff < `CS_SHOWN_BITS) begin
                        cs_cap_ff[g][frame_idx_ff[2:0]] <= I_CS_BIT;
                    end
                    if (I_FRAME_TICK && I_BLOCK_TICK) begin
                        cs_shown_ff[g] <= cs_cap_ff[g]; // RL14
                    end
                end
            end
        end
    endgenerate

    // master clock: half period is the frame length over 512
    logic [15:0] per_cnt_ff;
    logic [15:0] period_ff;
    logic [15:0] mck_cnt_ff;
    logic mck_ff;
    logic [15:0] mck_half;
    logic mck_toggle;
    logic mck_rise;

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            per_cnt_ff <= 16'h0000;
            period_ff <= 16'h0000;
        end else if (I_FRAME_TICK) begin
            per_cnt_ff <= 16'h0000;
            period_ff <= per_cnt_ff;
        end else if (per_cnt_ff != 16'hffff) begin
            per_cnt_ff <= per_cnt_ff + 16'h0001;
        end
    end

    // never faster than half the system clock; this limits the top rate
    assign mck_half = ((period_ff >> `MCK_PER_FRAME_SHIFT) == 16'h0000) ?
        16'h0001 : (period_ff >> `MCK_PER_FRAME_SHIFT);
    assign mck_toggle = (mck_cnt_ff + 16'h0001 >= mck_half);
    assign mck_rise = mck_toggle && !mck_ff;

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            mck_cnt_ff <= 16'h0000;
            mck_ff <= 1'b0;
        end else if (mck_toggle) begin
            mck_cnt_ff <= 16'h0000;
            mck_ff <= !mck_ff; // RL10
        end else begin
            mck_cnt_ff <= mck_cnt_ff + 16'h0001;
        end
    end

    assign O_MCK = mck_ff;

    // error clear: select high across more than eight master clocks
    logic [3:0] clr_cnt_ff;
    logic err_clr;

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int || !sel_s) begin
            clr_cnt_ff <= 4'h0;
        end else if (mck_rise && clr_cnt_ff != 4'hf) begin
            clr_cnt_ff <= clr_cnt_ff + 4'h1; // RL5
        end
    end

    assign err_clr = sel_s && mck_rise && clr_cnt_ff == `CLR_MCK_CYCLES; // RL5

    // error latch and frequency meter
    rx_report_pkg::err_code_t err_code;
    rx_report_pkg::freq_code_t freq_code;
    logic freq_upd;
    logic [6:0] err_cond;

    // priority: unlock over biphase over parity over the core's four
    assign err_cond = {!I_LOCKED, I_SUBFRAME_DONE && I_BIPHASE_ERR,
        I_SUBFRAME_DONE && I_PARITY_ERR, I_ERR_COND}; // RL15

    rx_err_latch u_err (
        .i_clk(I_SYS_CLK),
        .i_rst_n(rst_n_int),
        .i_clr(err_clr),
        .i_cond(err_cond),
        .o_code(err_code)
    );

    rx_freq_meter u_freq (
        .i_clk(I_SYS_CLK),
        .i_rst_n(rst_n_int),
        .i_ref_level(sub_s && !sel_s), // RL2
        .i_third_tick(third_tick),
        .i_locked(I_LOCKED),
        .o_code(freq_code),
        .o_upd(freq_upd)
    );

    // shared pins: status of one subframe, or frequency and error codes
    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            O_STATUS_PINS <= 6'h00;
        end else if (sel_s) begin
            O_STATUS_PINS <= sub_s ? cs_shown_ff[1] : cs_shown_ff[0]; // RL1 RL12
        end else begin
            O_STATUS_PINS <= {freq_code, err_code}; // RL3 RL12
        end
    end

    // per-sample error flag, forced while unlocked
    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            O_SAMPLE_ERR <= 1'b0;
        end else if (!I_LOCKED) begin
            O_SAMPLE_ERR <= 1'b1; // RL9
        end else if (I_SUBFRAME_DONE) begin
            O_SAMPLE_ERR <= I_PARITY_ERR || I_BIPHASE_ERR; // RL9
        end
    end

    // interrupt events; set beats the clearing read
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [3:0] events;
    logic locked_d_ff;
    rx_report_pkg::err_code_t err_d_ff;

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            locked_d_ff <= 1'b0;
            err_d_ff <= rx_report_pkg::ERR_NONE;
        end else begin
            locked_d_ff <= I_LOCKED;
            err_d_ff <= err_code;
        end
    end

    assign events = {I_FRAME_TICK && I_BLOCK_TICK, locked_d_ff && !I_LOCKED,
        freq_upd, err_code > err_d_ff};

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            status_ff <= `STATUS_RST;
        end else if (I_RD && I_ADDR == `ADDR_STATUS) begin
            status_ff <= events;
        end else begin
            status_ff <= status_ff | events;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            mask_ff <= `MASK_RST;
        end else if (I_WR && I_ADDR == `ADDR_MASK) begin
            mask_ff <= I_WDATA[`ST_WIDTH-1:0];
        end
    end

    // irq follows status one cycle later, from a flip-flop
    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(status_ff & mask_ff);
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge I_SYS_CLK) begin
        if (!rst_n_int || !I_RD) begin
            O_RDATA <= 8'h00;
        end else begin
            unique case (I_ADDR)
                `ADDR_STATUS: O_RDATA <= {4'h0, status_ff};
                `ADDR_MASK: O_RDATA <= {4'h0, mask_ff};
                `ADDR_INFO: O_RDATA <= {2'h0, freq_code, err_code};
                `ADDR_CS_SUB1: O_RDATA <= {2'h0, cs_shown_ff[0]};
                `ADDR_CS_SUB2: O_RDATA <= {2'h0, cs_shown_ff[1]};
                default: O_RDATA <= 8'h00;
            endcase
        end
    end

    // checks
    property p_sub_route;
        @(posedge I_SYS_CLK) disable iff (!rst_n_int)
        (sel_s && sub_s) |=> O_STATUS_PINS == $past(cs_shown_ff[1]);
    endproperty
    a_sub_route: assert property (p_sub_route) // RL1
        else $error("subframe 2 status not routed");

    property p_err_shown;
        @(posedge I_SYS_CLK) disable iff (!rst_n_int)
        !sel_s |=> O_STATUS_PINS == {$past(freq_code), $past(err_code)};
    endproperty
    a_err_shown: assert property (p_err_shown) // RL3
        else $error("report codes not shown with select low");

    sequence s_sel_rise;
        $rose(sel_s);
    endsequence

    property p_clear_waits;
        @(posedge I_SYS_CLK) disable iff (!rst_n_int)
        s_sel_rise |-> !err_clr [*8];
    endproperty
    a_clear_waits: assert property (p_clear_waits) // RL5
        else $error("error latch cleared too soon");

    property p_cbl_start;
        @(posedge I_SYS_CLK) disable iff (!rst_n_int)
        (I_FRAME_TICK && I_BLOCK_TICK) |=> O_BLOCK_START;
    endproperty
    a_cbl_start: assert property (p_cbl_start) // RL13
        else $error("block start not high at block boundary");

    property p_cs_hold;
        @(posedge I_SYS_CLK) disable iff (!rst_n_int)
        !(I_FRAME_TICK && I_BLOCK_TICK) |=> $stable(cs_shown_ff[0]);
    endproperty
    a_cs_hold: assert property (p_cs_hold) // RL14
        else $error("status changed away from block start");

    property p_sample_err;
        @(posedge I_SYS_CLK) disable iff (!rst_n_int)
        (I_SUBFRAME_DONE && I_PARITY_ERR) |=> O_SAMPLE_ERR;
    endproperty
    a_sample_err: assert property (p_sample_err) // RL9
        else $error("parity error not flagged");

    property p_fmt_reset;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        fmt_reset |=> O_STATUS_PINS == 6'h00 && !O_IRQ && !O_MCK;
    endproperty
    a_fmt_reset: assert property (p_fmt_reset) // RL11
        else $error("format pins did not reset the block");

    property p_irq;
        @(posedge I_SYS_CLK) disable iff (!rst_n_int)
        |(status_ff & mask_ff) |=> O_IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked status without interrupt");

endmodule
`default_nettype wire

/* File: dv/rx_host_model.sv */
// Purpose: host controller model driving the select and format pins
// Assumes: the block synchronises every pin it samples
// Notes:   reference clock keeps a fixed phase against the system clock
`timescale 1ns/1ps
`default_nettype none

module rx_host_model (
    // clock
    input wire logic i_clk,
    // pins to the block
    output logic o_report_sel,
    output logic o_subsel_freqclk,
    output logic [3:0] o_format_pins
);
    logic ref_ff = 1'b0;
    logic sub_ff = 1'b0;

    // free reference, 48 ns period, offset so its edges never meet a clock edge
    initial begin
        o_report_sel = 1'b0;
        o_format_pins = 4'h0;
        #7;
        forever #24 ref_ff = ~ref_ff;
    end

    // shared pin: subframe choice while select high, reference while low
    assign o_subsel_freqclk = o_report_sel ? sub_ff : ref_ff;

    // change select, then wait out the two-stage synchroniser and output register
    task automatic set_sel(input logic sel, input logic sub);
        @(posedge i_clk);
        o_report_sel <= sel;
        sub_ff <= sub;
        repeat (4) @(posedge i_clk);
        #1;
    endtask

    // all four format pins high restart the receiver
    task automatic format_reset();
        @(posedge i_clk);
        o_format_pins <= 4'hf;
        repeat (6) @(posedge i_clk);
        o_format_pins <= 4'h0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

/* File: dv/test_rx_error_freq_reporting.sv */
// Purpose: self-checking bench of the error and frequency reporting block
// Assumes: 16-cycle frames, so the master clock runs at its fastest
// Notes:   reference gives too few edges per window here; only invalid code checked
`include "rx_report_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_rx_error_freq_reporting;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} reg_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel, subfc, ftick = 1'b0, btick = 1'b0, sdone = 1'b0, sid = 1'b0;
    logic csb = 1'b0, perr = 1'b0, berr = 1'b0, locked = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] fmt, cond = 4'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
    logic [5:0] pins, pat1 = 6'h2d, pat2 = 6'h16, old1, old2;
    logic bstart, serr, recovered_master_clock, irq, seen_blk = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int fidx = 0;
    reg_row_t rows [5] = '{'{`ADDR_MASK, 8'hff, 8'h0f}, '{`ADDR_INFO, 8'hff, 8'h00},
        '{8'h14, 8'hff, 8'h00}, '{`ADDR_CS_SUB2, 8'hff, 8'h00}, '{`ADDR_MASK, 8'h00, 8'h00}};

    // 4 ns system clock
    always #2 clk = ~clk;

    rx_report_top dut_u (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_REPORT_SEL(sel),
        .I_SUBSEL_FREQCLK(subfc), .I_FORMAT_SELECT_PINS(fmt), .I_FRAME_TICK(ftick),
        .I_BLOCK_TICK(btick), .I_SUBFRAME_DONE(sdone), .I_SUBFRAME_ID(sid), .I_CS_BIT(csb),
        .I_PARITY_ERR(perr), .I_BIPHASE_ERR(berr), .I_LOCKED(locked), .I_ERR_COND(cond),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_STATUS_PINS(pins), .O_BLOCK_START(bstart), .O_SAMPLE_ERR(serr), .O_MCK(recovered_master_clock),
        .O_IRQ(irq));

    rx_host_model host_u (.i_clk(clk), .o_report_sel(sel), .o_subsel_freqclk(subfc),
        .o_format_pins(fmt));

    task automatic finish_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 3500 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask

    task automatic sub_pulse(input logic id, input logic c, input logic p, input logic b);
        @(posedge clk);
        sdone <= 1'b1;
        sid <= id;
        csb <= c;
        perr <= p;
        berr <= b;
        @(posedge clk);
        sdone <= 1'b0;
    endtask

    // one frame is 16 cycles; the first six frames of a block carry the status bits under test
    task automatic run_frames(input int n);
        repeat (n) begin
            @(posedge clk);
            ftick <= 1'b1;
            btick <= (fidx == 0);
            @(posedge clk);
            ftick <= 1'b0;
            btick <= 1'b0;
            seen_blk = seen_blk | (fidx == 0);
            sub_pulse(1'b0, (fidx < 6) ? pat1[fidx[2:0]] : 1'b0, 1'b0, 1'b0);
            sub_pulse(1'b1, (fidx < 6) ? pat2[fidx[2:0]] : 1'b0, 1'b0, 1'b0);
            if (seen_blk && (fidx == 31 || fidx == 32)) begin
                check({7'h0, bstart}, {7'h0, fidx == 31});
            end
            repeat (10) @(posedge clk);
            fidx = (fidx + 1) % 192;
        end
    endtask

    // clearing needs the master clock, so frames keep running meanwhile
    task automatic clear_latch();
        fork
            run_frames(5);
            begin
                host_u.set_sel(1'b1, 1'b0);
                repeat (40) @(posedge clk);
            end
        join
        host_u.set_sel(1'b0, 1'b0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #1;
        check({pins, irq, serr}, 8'h00);
        check({7'h0, bstart}, 8'h00);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // register table: write then read back each row
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a);
            check(rv, rows[i].e);
        end
        // capture in block A, refill in block B: pins must keep block A values
        run_frames(192);
        old1 = pat1;
        old2 = pat2;
        pat1 = ~pat1;
        pat2 = ~pat2;
        run_frames(8);
        host_u.set_sel(1'b1, 1'b0);
        check({2'h0, pins}, {2'h0, old1});
        host_u.set_sel(1'b1, 1'b1);
        check({2'h0, pins}, {2'h0, old2});
        rd_reg(`ADDR_CS_SUB2);
        check(rv, {2'h0, old2});
        // interrupt: masked, unmasked, cleared by reading status
        check({7'h0, irq}, 8'h00);
        wr_reg(`ADDR_MASK, 8'h08);
        repeat (2) @(posedge clk);
        #1;
        check({7'h0, irq}, 8'h01);
        rd_reg(`ADDR_STATUS);
        check(rv, 8'h0a);
        repeat (2) @(posedge clk);
        #1;
        check({7'h0, irq}, 8'h00);
        // 16-cycle frames put the master clock at its limit: one toggle a cycle
        rv = {7'h0, recovered_master_clock};
        @(posedge clk);
        #1;
        check({7'h0, recovered_master_clock}, {7'h0, ~rv[0]});
        // error latch: higher code held, lower later one ignored
        clear_latch();
        check({5'h0, pins[2:0]}, 8'h00);
        @(posedge clk);
        cond <= 4'h2;
        repeat (3) @(posedge clk);
        cond <= 4'h1;
        repeat (6) @(posedge clk);
        #1;
        check({5'h0, pins[2:0]}, {5'h0, rx_report_pkg::ERR_COND1});
        @(posedge clk);
        cond <= 4'h0;
        clear_latch();
        check({5'h0, pins[2:0]}, 8'h00);
        // sample error flag for every parity and biphase combination
        for (int i = 0; i < 4; i++) begin
            sub_pulse(1'b0, 1'b0, i[0], i[1]);
            #1;
            check({7'h0, serr}, {7'h0, i[0] | i[1]});
        end
        @(posedge clk);
        locked <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check({7'h0, serr}, 8'h01);
        check({5'h0, pins[2:0]}, {5'h0, rx_report_pkg::ERR_UNLOCK});
        check({5'h0, pins[5:3]}, {5'h0, rx_report_pkg::FREQ_NONE});
        @(posedge clk);
        locked <= 1'b1;
        // format pin reset returns mask and pins to their reset state
        host_u.format_reset();
        rd_reg(`ADDR_MASK);
        check(rv, {4'h0, `MASK_RST});
        check({pins, irq, serr}, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
